// >>> pkg/jms_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef JMS_REGS_SVH
`define JMS_REGS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define JMS_OFF_CTRL 12'h000
`define JMS_OFF_SETPOINT 12'h004
`define JMS_OFF_JOG_FREQ 12'h008
`define JMS_OFF_JOG_STOP 12'h00C
`define JMS_OFF_MAX_FREQ 12'h010
`define JMS_OFF_START_FREQ 12'h014
`define JMS_OFF_SETTLE 12'h018
`define JMS_OFF_STORE 12'h01C
`define JMS_OFF_STATUS 12'h020
`define JMS_OFF_MONITOR 12'h024
`define JMS_OFF_PRESET0 12'h040
`define JMS_OFF_PRESET15 12'h07C

// ----------------------------------------------------------------------
// fields and codes
// ----------------------------------------------------------------------
`define JMS_CTRL_BITMODE 0
`define JMS_STORE_KEY 0
`define JMS_JOG_CODE_RUN_OK 3'h3
`define JMS_JOG_CODE_MAX 3'h5

// ----------------------------------------------------------------------
// reset values (frequencies in 0.01 Hz)
// ----------------------------------------------------------------------
`define JMS_RST_JOG_FREQ 16'h0258
`define JMS_RST_JOG_STOP 3'h4
`define JMS_RST_MAX_FREQ 16'h1388
`define JMS_RST_START_FREQ 16'h0032
`define JMS_RST_SETTLE 8'h00
`define JMS_JOG_FREQ_LIMIT 16'h03E7
`define JMS_SETTLE_LIMIT 8'hC8

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define JMS_CLK_PERIOD_NS 20
`define JMS_SETTLE_UNIT_NS 10000000
`define JMS_SETTLE_UNIT_CYC (`JMS_SETTLE_UNIT_NS / `JMS_CLK_PERIOD_NS)

`endif

// >>> pkg/jms_pkg.sv
// types shared by the jog and multi-speed select block
package jms_pkg;

  typedef enum logic [2:0] {
    JMS_IDLE = 3'b001,
    JMS_RUN = 3'b010,
    JMS_JOG = 3'b100
  } jms_state_t;

  typedef enum logic [1:0] {
    JMS_FREE_RUN = 2'h0,
    JMS_DECEL = 2'h1,
    JMS_DC_BRAKE = 2'h2
  } jms_stop_t;

  typedef struct packed {
    logic [3:0] bin_speed_sel;
    logic [7:1] bitmode_speed_sel;
    logic jog_input;
    logic forward_run_input;
    logic reverse_run_input;
  } jms_term_t;

  typedef struct packed {
    logic run;
    logic reverse;
    logic jog_active;
    logic ramp_bypass;
    logic [1:0] stop_method;
  } jms_drive_t;

endpackage

// >>> rtl/jms_top.sv
// jog and multi-speed command selection with apb register file
// ----------------------------------------------------------------------
// Function
// - output frequency readable in monitor register
// - stopped, select preset, edit, store copies setpoint
// - preset changes only on store key or a write to its preset register
// - bit-mode select inputs choose active preset
// - output limited to maximum frequency
// - jog frequency used, range start to 9.99
// - jog frequency 6.00, stop code 04 at reset
// - jog frequency applied instantly, no ramp
// - stop codes 0-2 jog locked, 3-5 allowed
// - running with codes 0-2 ignores jog request
// - setpoint writes accepted during jog
// - jog on runs at jog frequency, off stops
// - no jog below start frequency or zero
// - binary mode four bits index presets 1-15, zero selects setpoint
// - bit mode lowest active input wins, none zero
// - select changes masked for settle time
// ----------------------------------------------------------------------
`timescale 1ns/1ns
`include "jms_regs.svh"

module jms_top #(
  parameter int FW = 16,
  parameter int NPRESET = 16,
  parameter int SETTLE_UNIT_CYC = `JMS_SETTLE_UNIT_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire jms_pkg::jms_term_t term_i,
  output logic [FW-1:0] out_freq_o,
  output jms_pkg::jms_drive_t drive_o
);

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic acc;
  logic wr;
  logic is_preset;
  logic mapped;
  logic [3:0] pidx;
  assign acc = psel_i & penable_i;
  assign wr = acc & pwrite_i;
  assign is_preset = (paddr_i >= `JMS_OFF_PRESET0) && (paddr_i <= `JMS_OFF_PRESET15)
                     && (paddr_i[1:0] == 2'h0);
  assign pidx = paddr_i[5:2];
  assign mapped = is_preset || (paddr_i[1:0] == 2'h0 && paddr_i <= `JMS_OFF_MONITOR);
  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~mapped;

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  logic bitmode_q;
  logic [FW-1:0] setpoint_q;
  logic [FW-1:0] jog_freq_q;
  logic [2:0] jog_stop_q;
  logic [FW-1:0] max_freq_q;
  logic [FW-1:0] start_freq_q;
  logic [7:0] settle_q;
  logic store_key;
  logic running;
  logic [3:0] sel_q;
  logic [FW-1:0] preset_q [NPRESET];
  jms_pkg::jms_state_t state_q;

  assign running = (state_q != jms_pkg::JMS_IDLE);
  assign store_key = wr && paddr_i == `JMS_OFF_STORE && pwdata_i[`JMS_STORE_KEY];

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bitmode_q <= 1'b0;
      max_freq_q <= `JMS_RST_MAX_FREQ;
      start_freq_q <= `JMS_RST_START_FREQ;
      settle_q <= `JMS_RST_SETTLE;
    end else if (wr) begin
      case (paddr_i)
        `JMS_OFF_CTRL: begin
          bitmode_q <= pwdata_i[`JMS_CTRL_BITMODE];
        end
        `JMS_OFF_MAX_FREQ: begin
          max_freq_q <= pwdata_i[FW-1:0];
        end
        `JMS_OFF_START_FREQ: begin
          start_freq_q <= pwdata_i[FW-1:0];
        end
        `JMS_OFF_SETTLE: begin
          // longer settle times are clipped, not ignored
          settle_q <= (pwdata_i > 32'(`JMS_SETTLE_LIMIT)) ? `JMS_SETTLE_LIMIT : pwdata_i[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // setpoint is writable in every state, jog included
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      setpoint_q <= '0;
    end else if (wr && paddr_i == `JMS_OFF_SETPOINT) begin
      setpoint_q <= pwdata_i[FW-1:0];
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      jog_freq_q <= `JMS_RST_JOG_FREQ;
      jog_stop_q <= `JMS_RST_JOG_STOP;
    end else if (wr) begin
      if (paddr_i == `JMS_OFF_JOG_FREQ) begin
        // upper bound clipped here; lower bound checked at jog start
        jog_freq_q <= (pwdata_i > 32'(`JMS_JOG_FREQ_LIMIT)) ? `JMS_JOG_FREQ_LIMIT
                      : pwdata_i[FW-1:0];
      end
      // stop code is a stop-mode edit only; unknown codes are dropped
      if (paddr_i == `JMS_OFF_JOG_STOP && !running && pwdata_i[2:0] <= `JMS_JOG_CODE_MAX) begin
        jog_stop_q <= pwdata_i[2:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // preset table
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NPRESET; gi++) begin : g_preset
      always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
          preset_q[gi] <= '0;
        end else if (store_key && !running && sel_q == 4'(gi)) begin
          preset_q[gi] <= setpoint_q;
        end else if (wr && is_preset && pidx == 4'(gi)) begin
          preset_q[gi] <= pwdata_i[FW-1:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // speed select decode and settle mask
  // ----------------------------------------------------------------------
  logic [3:0] raw_idx;
  always_comb begin
    raw_idx = 4'h0;
    if (bitmode_q) begin
      for (int i = 7; i >= 1; i--) begin
        if (term_i.bitmode_speed_sel[i]) begin
          raw_idx = 4'(i);
        end
      end
    end else begin
      raw_idx = term_i.bin_speed_sel;
    end
  end

  logic [3:0] pend_q;
  logic [$clog2(SETTLE_UNIT_CYC+1)-1:0] tick_q;
  logic [7:0] units_q;
  logic changed;
  assign changed = (raw_idx != pend_q);

  // a new combination restarts the mask so switch bounce never selects
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pend_q <= 4'h0;
      tick_q <= '0;
      units_q <= 8'h00;
    end else if (changed) begin
      pend_q <= raw_idx;
      tick_q <= '0;
      units_q <= 8'h00;
    end else if (units_q < settle_q) begin
      if (tick_q == ($bits(tick_q))'(SETTLE_UNIT_CYC - 1)) begin
        tick_q <= '0;
        units_q <= units_q + 8'h01;
      end else begin
        tick_q <= tick_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sel_q <= 4'h0;
    end else if (!changed && units_q >= settle_q) begin
      sel_q <= pend_q;
    end
  end

  // ----------------------------------------------------------------------
  // run and jog sequencing
  // ----------------------------------------------------------------------
  logic run_req;
  logic jog_ok;
  logic jog_run_ok;
  logic [1:0] stop_of_code;
  jms_pkg::jms_stop_t stop_q;
  assign run_req = term_i.forward_run_input | term_i.reverse_run_input;
  assign jog_ok = (jog_freq_q != '0) && (jog_freq_q >= start_freq_q);
  assign jog_run_ok = (jog_stop_q >= `JMS_JOG_CODE_RUN_OK);
  assign stop_of_code = (jog_stop_q >= `JMS_JOG_CODE_RUN_OK)
                        ? 2'(jog_stop_q - `JMS_JOG_CODE_RUN_OK) : jog_stop_q[1:0];

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= jms_pkg::JMS_IDLE;
    end else begin
      case (state_q)
        jms_pkg::JMS_IDLE: begin
          if (run_req && term_i.jog_input && jog_ok) begin
            state_q <= jms_pkg::JMS_JOG;
          end else if (run_req && !term_i.jog_input) begin
            state_q <= jms_pkg::JMS_RUN;
          end
        end
        jms_pkg::JMS_RUN: begin
          if (!run_req) begin
            state_q <= jms_pkg::JMS_IDLE;
          end else if (term_i.jog_input && jog_ok && jog_run_ok) begin
            state_q <= jms_pkg::JMS_JOG;
          end
        end
        jms_pkg::JMS_JOG: begin
          if (!run_req || !term_i.jog_input) begin
            state_q <= jms_pkg::JMS_IDLE;
          end
        end
        default: begin
          state_q <= jms_pkg::JMS_IDLE;
        end
      endcase
    end
  end

  // stop method latched at jog release; ordinary run stop is decel
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      stop_q <= jms_pkg::JMS_DECEL;
    end else if (state_q == jms_pkg::JMS_JOG && (!run_req || !term_i.jog_input)) begin
      stop_q <= jms_pkg::jms_stop_t'(stop_of_code);
    end else if (state_q == jms_pkg::JMS_RUN && !run_req) begin
      stop_q <= jms_pkg::JMS_DECEL;
    end
  end

  // ----------------------------------------------------------------------
  // output frequency
  // ----------------------------------------------------------------------
  logic [FW-1:0] target;
  logic [FW-1:0] out_q;
  logic rev_q;
  always_comb begin
    target = '0;
    case (state_q)
      jms_pkg::JMS_JOG: target = jog_freq_q;
      jms_pkg::JMS_RUN: target = (sel_q == 4'h0) ? setpoint_q : preset_q[sel_q];
      default: target = '0;
    endcase
  end

  // jog value goes out unramped; downstream ramp sees ramp_bypass
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_q <= '0;
      rev_q <= 1'b0;
    end else begin
      out_q <= (target > max_freq_q) ? max_freq_q : target;
      if (run_req) begin
        rev_q <= term_i.reverse_run_input & ~term_i.forward_run_input;
      end
    end
  end

  assign out_freq_o = out_q;
  assign drive_o.run = (state_q != jms_pkg::JMS_IDLE);
  assign drive_o.reverse = rev_q;
  assign drive_o.jog_active = (state_q == jms_pkg::JMS_JOG);
  assign drive_o.ramp_bypass = (state_q == jms_pkg::JMS_JOG);
  assign drive_o.stop_method = stop_q;

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  always_comb begin
    prdata_o = 32'h0000_0000;
    if (acc && !pwrite_i) begin
      if (is_preset) begin
        prdata_o[FW-1:0] = preset_q[pidx];
      end else begin
        case (paddr_i)
          `JMS_OFF_CTRL: prdata_o[0] = bitmode_q;
          `JMS_OFF_SETPOINT: prdata_o[FW-1:0] = setpoint_q;
          `JMS_OFF_JOG_FREQ: prdata_o[FW-1:0] = jog_freq_q;
          `JMS_OFF_JOG_STOP: prdata_o[2:0] = jog_stop_q;
          `JMS_OFF_MAX_FREQ: prdata_o[FW-1:0] = max_freq_q;
          `JMS_OFF_START_FREQ: prdata_o[FW-1:0] = start_freq_q;
          `JMS_OFF_SETTLE: prdata_o[7:0] = settle_q;
          `JMS_OFF_STATUS: prdata_o[10:0] = {sel_q, jog_ok, stop_q, rev_q, state_q};
          `JMS_OFF_MONITOR: prdata_o[FW-1:0] = out_q;
          default: prdata_o = 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_monitor_read: assert property (
    acc && !pwrite_i && paddr_i == `JMS_OFF_MONITOR |-> prdata_o[FW-1:0] == out_freq_o)
    else $error("monitor read differs from output frequency");

  a_store_commit: assert property (
    store_key && !running |=> preset_q[$past(sel_q)] == $past(setpoint_q))
    else $error("store key did not commit setpoint");

  a_preset_hold: assert property (
    !(store_key && sel_q == 4'h1) && !(wr && is_preset && pidx == 4'h1)
    |=> $stable(preset_q[1]))
    else $error("preset changed without store");

  a_max_limit: assert property (
    out_freq_o <= max_freq_q || $changed(max_freq_q))
    else $error("output above maximum frequency");

  a_jog_instant: assert property (
    $rose(drive_o.jog_active) |=> out_freq_o == ((jog_freq_q > max_freq_q) ? max_freq_q
                                                 : jog_freq_q))
    else $error("jog frequency not applied at once");

  a_jog_locked: assert property (
    state_q == jms_pkg::JMS_RUN && !jog_run_ok |=> state_q != jms_pkg::JMS_JOG)
    else $error("jog accepted while running with locked code");

  a_jog_valid: assert property (
    $rose(drive_o.jog_active) |-> $past(jog_ok))
    else $error("jog started with invalid jog frequency");

  a_jog_stop: assert property (
    $fell(drive_o.jog_active) |-> drive_o.stop_method == $past(stop_of_code))
    else $error("wrong stop method after jog");

  a_settle_mask: assert property (
    changed && settle_q != 8'h00 ##1 settle_q != 8'h00 |-> $stable(sel_q) [*2])
    else $error("select changed before settle time");

  a_reset_dflt: assert property (@(posedge sys_clk_i) disable iff (1'b0)
    reset_i ##1 !reset_i |-> jog_freq_q == `JMS_RST_JOG_FREQ && jog_stop_q == `JMS_RST_JOG_STOP)
    else $error("jog defaults wrong after reset");

  c_jog_from_idle: cover property (state_q == jms_pkg::JMS_IDLE ##1 state_q == jms_pkg::JMS_JOG);
  c_jog_from_run: cover property (state_q == jms_pkg::JMS_RUN ##1 state_q == jms_pkg::JMS_JOG);
  c_store: cover property (store_key && !running);
  c_bitmode_run: cover property (bitmode_q && state_q == jms_pkg::JMS_RUN && sel_q == 4'h7);

endmodule

// >>> test/jms_term_model.sv
// behavioural terminal strip driving the select inputs
`timescale 1ns/1ns
module jms_term_model (
  input wire logic sys_clk_i,
  input wire logic strict_i,
  input wire jms_pkg::jms_term_t req_i,
  output jms_pkg::jms_term_t term_o
);
  logic run_now;
  logic run_req;
  assign run_now = term_o.forward_run_input | term_o.reverse_run_input;
  assign run_req = req_i.forward_run_input | req_i.reverse_run_input;
  initial term_o = '0;
  // ----------------------------------------------------------------------
  // controller ordering
  // ----------------------------------------------------------------------
  // strict off lets a scenario break the ordering on purpose
  // run and jog only ever come from the terminals here
  always @(posedge sys_clk_i) begin
    jms_pkg::jms_term_t nxt;
    nxt = req_i;
    if (strict_i && run_now) begin
      nxt.jog_input = term_o.jog_input;
    end
    if (strict_i && !run_now && run_req && req_i.jog_input && !term_o.jog_input) begin
      nxt.forward_run_input = 1'b0;
      nxt.reverse_run_input = 1'b0;
    end
    term_o <= nxt;
  end
endmodule

// >>> test/tb_top.sv
// self-checking bench for the jog and multi-speed select block
`timescale 1ns/1ns
`include "jms_regs.svh"
module tb_top;
  typedef struct {logic m; logic [3:0] b; logic [7:1] s; int idx;} jms_row_t;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, strict, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [15:0] out_freq, e;
  jms_pkg::jms_term_t req, term;
  jms_pkg::jms_drive_t drv;
  int error_cnt = 0;
  int cmp_count = 0;
  int c;
  // bin rows other than the 4'hF row carry junk on bit inputs, and bit rows carry junk on bin inputs
  jms_row_t rows[8] = '{'{0, 4'h1, 7'h7F, 1}, '{0, 4'h5, 7'h7F, 5}, '{0, 4'hF, 7'h00, 15},
    '{0, 4'h0, 7'h7F, 0}, '{1, 4'hA, 7'h01, 1}, '{1, 4'hA, 7'h54, 3},
    '{1, 4'hF, 7'h40, 7}, '{1, 4'hF, 7'h00, 0}};

  always #10 clk = ~clk;

  jms_term_model i_term (.sys_clk_i(clk), .strict_i(strict), .req_i(req), .term_o(term));
  jms_top #(.SETTLE_UNIT_CYC(4)) i_dut (.sys_clk_i(clk), .reset_i(rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .term_i(term),
    .out_freq_o(out_freq), .drive_o(drv));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] pv(input int i);
    return (i == 5) ? 16'h1770 : 16'(i * 300);
  endfunction

  task automatic report_and_stop();
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, x, s);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(nm, r, x);
  endtask

  task automatic set_t(input logic [3:0] b, input logic [7:1] s, input logic j,
                       input logic f, input logic r);
    @(posedge clk);
    req <= '{bin_speed_sel: b, bitmode_speed_sel: s, jog_input: j,
             forward_run_input: f, reverse_run_input: r};
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wait_out(input logic [15:0] x);
    int n;
    n = 0;
    while (out_freq !== x && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk("out_freq", {16'h0, out_freq}, {16'h0, x});
    if (n >= 60) report_and_stop();
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    req = '0; strict = 1; last_err = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 1; i < 16; i++) wr(`JMS_OFF_PRESET0 + 12'(4 * i), {16'h0, pv(i)});
    wr(`JMS_OFF_SETPOINT, 32'h0000_0309);
    foreach (rows[i]) begin
      wr(`JMS_OFF_CTRL, {31'h0, rows[i].m});
      set_t(rows[i].b, rows[i].s, 1'b0, 1'b1, 1'b0);
      e = (rows[i].idx == 0) ? 16'h0309 : pv(rows[i].idx);
      if (e > `JMS_RST_MAX_FREQ) e = `JMS_RST_MAX_FREQ;
      wait_out(e);
      rdchk("monitor", `JMS_OFF_MONITOR, {16'h0, e});
      apb(1'b0, `JMS_OFF_STATUS, 32'h0, rv);
      chk("sel_index", {28'h0, rv[10:7]}, 32'(rows[i].idx));
    end
    // preset programming while stopped
    wr(`JMS_OFF_CTRL, 32'h0);
    wr(`JMS_OFF_MAX_FREQ, 32'h0000_1770);
    set_t(4'h5, 7'h00, 1'b0, 1'b1, 1'b0);
    wait_out(16'h1770);
    set_t(4'h2, 7'h00, 1'b0, 1'b0, 1'b0);
    wr(`JMS_OFF_SETPOINT, 32'h0000_04D2);
    rdchk("preset2", 12'h048, {16'h0, pv(2)});
    wr(`JMS_OFF_STORE, 32'h1);
    rdchk("preset2", 12'h048, 32'h0000_04D2);
    rdchk("setpoint", `JMS_OFF_SETPOINT, 32'h0000_04D2);
    apb(1'b0, 12'h030, 32'h0, rv);
    chk("unmapped_err", {31'h0, last_err}, 32'h1);
    chk("unmapped_data", rv, 32'h0);
    // second reset while running
    set_t(4'h3, 7'h00, 1'b0, 1'b1, 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    req <= '0;
    @(negedge clk);
    chk("out_freq", {16'h0, out_freq}, 32'h0);
    chk("run", {31'h0, drv.run}, 32'h0);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdchk("jog_freq", `JMS_OFF_JOG_FREQ, 32'h0000_0258);
    rdchk("jog_stop", `JMS_OFF_JOG_STOP, 32'h4);
    rdchk("status", `JMS_OFF_STATUS, 32'h0000_0051);
    rdchk("preset3", 12'h04C, 32'h0);
    // jog with a preset selected
    wr(12'h054, 32'h0000_07D0);
    set_t(4'h5, 7'h00, 1'b1, 1'b1, 1'b0);
    wait_out(16'h0258);
    chk("jog_active", {31'h0, drv.jog_active}, 32'h1);
    chk("ramp_bypass", {31'h0, drv.ramp_bypass}, 32'h1);
    wr(`JMS_OFF_SETPOINT, 32'h0000_0141);
    rdchk("setpoint", `JMS_OFF_SETPOINT, 32'h0000_0141);
    wr(`JMS_OFF_JOG_FREQ, 32'h0000_05DC);
    rdchk("jog_freq", `JMS_OFF_JOG_FREQ, 32'h0000_03E7);
    set_t(4'h5, 7'h00, 1'b0, 1'b0, 1'b0);
    chk("run", {31'h0, drv.run}, 32'h0);
    chk("stop_method", {30'h0, drv.stop_method}, 32'h1);
    wr(`JMS_OFF_JOG_STOP, 32'h5);
    wr(`JMS_OFF_JOG_STOP, 32'h6);
    rdchk("jog_stop", `JMS_OFF_JOG_STOP, 32'h5);
    set_t(4'h5, 7'h00, 1'b1, 1'b1, 1'b0);
    wait_out(16'h03E7);
    set_t(4'h5, 7'h00, 1'b0, 1'b0, 1'b0);
    chk("stop_method", {30'h0, drv.stop_method}, 32'h2);
    // jog raised while already running
    for (int k = 0; k < 2; k++) begin
      c = 3 * k;
      wr(`JMS_OFF_JOG_STOP, 32'(c));
      set_t(4'h5, 7'h00, 1'b0, 1'b1, 1'b0);
      strict <= 1'b0;
      set_t(4'h5, 7'h00, 1'b1, 1'b1, 1'b0);
      wait_out((c >= 3) ? 16'h03E7 : 16'h07D0);
      chk("jog_active", {31'h0, drv.jog_active}, (c >= 3) ? 32'h1 : 32'h0);
      set_t(4'h5, 7'h00, 1'b0, 1'b0, 1'b0);
      chk("stop_method", {30'h0, drv.stop_method}, (c >= 3) ? 32'h0 : 32'h1);
      strict <= 1'b1;
    end
    // jog frequency zero or under the start frequency
    wr(`JMS_OFF_JOG_STOP, 32'h4);
    for (int k = 0; k < 2; k++) begin
      wr(`JMS_OFF_JOG_FREQ, (k == 0) ? 32'h0 : 32'h0000_001E);
      set_t(4'h0, 7'h00, 1'b1, 1'b1, 1'b0);
      chk("run", {31'h0, drv.run}, 32'h0);
      chk("jog_active", {31'h0, drv.jog_active}, 32'h0);
      set_t(4'h0, 7'h00, 1'b0, 1'b0, 1'b0);
    end
    // reverse run and select settling
    wr(`JMS_OFF_SETTLE, 32'h0000_00FA);
    rdchk("settle", `JMS_OFF_SETTLE, 32'h0000_00C8);
    wr(`JMS_OFF_SETTLE, 32'h0);
    set_t(4'h5, 7'h00, 1'b0, 1'b0, 1'b1);
    wait_out(16'h07D0);
    chk("reverse", {31'h0, drv.reverse}, 32'h1);
    wr(`JMS_OFF_SETTLE, 32'h3);
    @(posedge clk);
    req.bin_speed_sel <= 4'h0;
    repeat (8) @(negedge clk);
    chk("out_freq", {16'h0, out_freq}, 32'h0000_07D0);
    wait_out(16'h0141);
    set_t(4'h0, 7'h00, 1'b0, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule
